// ==== include/sagp_pkg.sv ====
// Shared constants for the small-angle gauge PWM channel
package sagp_pkg;
	// Serial frame layout
	localparam int FRAME_BITS = 16; // Bits in one write frame
	localparam int ADDR_LSB = 1; // Address field occupies D3:D1
	localparam logic [2:0] ADDR_SMALL_GAUGE = 3'h4; // Address of the small-angle gauge channel
	localparam int DUTY_POS = 6; // Duty field starts at D6
	localparam int DUTY_W = 9; // Duty field width
	localparam logic [4:0] FRAME_BITS_CNT = 5'h10; // Bit count of a complete frame
	// Generator
	localparam logic [8:0] PWM_LAST = 9'h1FF; // Last count of a 512-step period
	localparam logic [8:0] DUTY_RESET = 9'h000; // 0% duty after reset
	localparam logic [7:0] OSC_DIV_DEF = 8'h04; // Core cycles per oscillator cycle
	// Timing
	localparam int CLK_MHZ = 125; // Core clock rate in MHz
	localparam int LATENCY_US = 256; // Longest write-to-output delay in microseconds
	localparam int LATENCY_CYC = LATENCY_US * CLK_MHZ; // Same delay in core cycles
endpackage

// ==== logic/sagp_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; a level is accepted once stages two and three agree
module sagp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_r; // Metastable stage, read only by s2_r
	logic [W-1:0] s2_r; // Second stage
	logic [W-1:0] s3_r; // Third stage
	logic [W-1:0] lvl_r; // Accepted level

	// Shift chain and agreement filter
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			lvl_r <= INIT;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Only bits whose late stages agree are taken over
			lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r)) | (lvl_r & s2_r & s3_r);
		end
	end

	assign dout = lvl_r;
endmodule

// ==== logic/sagp_channel.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Frame bits D6..D14 are the duty, unconverted
// - D0, D15, D4, D5 play no part
// - Output inverted: 0% high, duty 0x1FF low for 511 of 512 steps
// - Chip select rising edge captures duty into holding latch
// - Held duty loads only at period start
// - Write to output within 256 microseconds
// - Newer write overwrites unloaded held value
// - Reset gives 0% duty, output high
// - Period is 512 oscillator cycles
// - D14 is duty LSB, D6 its MSB
module sagp_channel
	import sagp_pkg::*;
#(
	parameter logic [7:0] OSC_DIV = sagp_pkg::OSC_DIV_DEF,
	parameter int LAT_CYC = sagp_pkg::LATENCY_CYC
) (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic CHIP_SELECT_N,
	input wire logic SER_CLK,
	input wire logic SER_DATA,
	output logic PWM_OUT
);
	import sagp_pkg::*;

	// Whole channel state
	typedef struct packed {
		logic [15:0] shift; // Frame shift register, D0 lands in bit 0
		logic [4:0] nbits; // Bits received in this frame
		logic [8:0] hold; // Intermediate duty latch
		logic hold_valid; // Latch waits for a period boundary
		logic [8:0] duty; // Duty in use by the generator
		logic [8:0] cnt; // Oscillator-rate period counter
		logic [7:0] div; // Core-to-oscillator divider
		logic pwm_out; // Output pin level
		logic sclk_q; // Previous serial clock level
		logic cs_q; // Previous chip select level
	} sagp_state_s;

	// Registered state and its next value
	sagp_state_s st_r; // Registered state
	sagp_state_s st_nxt; // Next state
	// Filtered pins and the strobes derived from them
	logic [2:0] pins_f; // Filtered pin levels
	logic cs_f; // Filtered chip select, active low
	logic sclk_f; // Filtered serial clock
	logic sdat_f; // Filtered serial data
	logic sclk_rise; // Serial clock rising edge
	logic cs_rise; // End of frame
	logic frame_ok; // Complete frame aimed at this channel
	logic osc_tick; // One core cycle per oscillator cycle
	logic [8:0] dec_duty; // Duty decoded from the frame

	// Field D6..D14 with D14 as LSB, so the order is reversed
	function automatic logic [8:0] duty_of(input logic [15:0] f);
		logic [8:0] d;
		d = '0;
		for (int i = 0; i < DUTY_W; i++)
			d[DUTY_W-1-i] = f[DUTY_POS+i];
		return d;
	endfunction

	// Pins come from the host's domain
	// Three to four cycles of delay, well inside one link half period
	sagp_sync #(.W(3), .INIT(3'h1)) u_sync (
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.din({SER_DATA, SER_CLK, CHIP_SELECT_N}),
		.dout(pins_f)
	);

	assign cs_f = pins_f[0];
	assign sclk_f = pins_f[1];
	assign sdat_f = pins_f[2];
	// Edge detectors; their history resets to the pins' idle levels, so no false edge
	assign sclk_rise = sclk_f & ~st_r.sclk_q;
	assign cs_rise = cs_f & ~st_r.cs_q;
	// Only the address and length are checked; D0, D4, D5, D15 never looked at
	assign frame_ok = (st_r.nbits == FRAME_BITS_CNT) &&
		(st_r.shift[ADDR_LSB +: 3] == ADDR_SMALL_GAUGE);
	// One tick per OSC_DIV core cycles; an OSC_DIV of one ticks every cycle
	assign osc_tick = (st_r.div == OSC_DIV - 8'h01);
	assign dec_duty = duty_of(st_r.shift);

	// Next-state logic
	always_comb
	begin
		// Hold everything unless a branch below says otherwise
		st_nxt = st_r;
		// Edge history for the detectors
		st_nxt.sclk_q = sclk_f;
		st_nxt.cs_q = cs_f;
		// Receiver: shift on serial clock rise while selected, first bit is D0
		if (!cs_f && st_r.cs_q)
		begin
			// Select just fell: a new frame starts
			st_nxt.nbits = 5'h00;
		end
		else if (!cs_f && sclk_rise)
		begin
			// Newest bit enters at the top, so D0 ends in bit 0
			st_nxt.shift = {sdat_f, st_r.shift[15:1]};
			// Saturate so an overlong frame is rejected rather than wrapped
			if (st_r.nbits != 5'h1F)
				st_nxt.nbits = st_r.nbits + 5'h01;
		end
		// Oscillator-rate divider
		st_nxt.div = osc_tick ? 8'h00 : st_r.div + 8'h01;
		if (osc_tick)
		begin
			st_nxt.cnt = st_r.cnt + 9'h001; // Wraps after 512 steps
			// Last step of the period reached
			if (st_r.cnt == PWM_LAST)
			begin
				// Boundary: take the held value, never mid-period
				if (st_r.hold_valid)
				begin
					st_nxt.duty = st_r.hold; // At most one period after capture
					st_nxt.hold_valid = 1'b0;
				end
			end
			// Low while below duty, so 0 never goes low
			// Limitation: nine bits reach 511 of 512 steps low, never a full period
			st_nxt.pwm_out = !(st_nxt.cnt < st_nxt.duty);
		end
		// Capture after the boundary logic so a simultaneous write is kept
		if (cs_rise && frame_ok)
		begin
			st_nxt.hold = dec_duty; // Older unloaded value is lost
			st_nxt.hold_valid = 1'b1;
		end
	end

	// State register
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			// Duty 0%, output high, select history idle high
			st_r <= '0;
			st_r.duty <= DUTY_RESET;
			st_r.pwm_out <= 1'b1;
			st_r.cs_q <= 1'b1;
		end
		else
		begin
			// Every field moves together
			st_r <= st_nxt;
		end
	end

	// Pin comes straight from the state register, never from logic
	assign PWM_OUT = st_r.pwm_out;

	// Cycles a held value has waited, for the latency check
	// Kept apart from the state struct: it only feeds an assertion
	logic [31:0] wait_r;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			// Nothing held after reset
			wait_r <= '0;
		end
		else if (!st_r.hold_valid || (cs_rise && frame_ok))
		begin
			// Idle, or a fresh capture restarts the wait
			wait_r <= '0;
		end
		else
		begin
			// No saturation needed: the bound trips long before a wrap
			wait_r <= wait_r + 32'h00000001;
		end
	end

	// Every check below runs on the core clock and sleeps through reset
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);

	duty_zero_high_a: assert property (st_r.duty == 9'h000 |-> PWM_OUT)
		else $error("Output low with zero duty");
	reset_duty_a: assert property ($rose(ARST_N) |-> st_r.duty == DUTY_RESET && PWM_OUT)
		else $error("Duty not zero after reset");
	out_compare_a: assert property (osc_tick |=> PWM_OUT == !(st_r.cnt < st_r.duty))
		else $error("Output level disagrees with counter");
	load_boundary_a: assert property (st_r.duty != $past(st_r.duty) |-> st_r.cnt == 9'h000)
		else $error("Duty changed mid-period");
	period_wrap_a: assert property (osc_tick && st_r.cnt == PWM_LAST |=> st_r.cnt == 9'h000)
		else $error("Period not 512 steps");
	capture_latch_a: assert property (cs_rise && frame_ok |=> st_r.hold_valid && st_r.hold == $past(dec_duty))
		else $error("Held duty not captured");
	field_map_a: assert property (cs_rise && frame_ok
		|=> st_r.hold[0] == $past(st_r.shift[14]) && st_r.hold[8] == $past(st_r.shift[6]))
		else $error("Duty bit order wrong");
	other_addr_a: assert property (cs_rise && !frame_ok |=> st_r.hold == $past(st_r.hold))
		else $error("Foreign frame altered latch");
	latency_bound_a: assert property (wait_r <= 32'(LAT_CYC))
		else $error("Held duty waited too long");
	// Away from a boundary the running duty never moves
	duty_steady_a: assert property (!(osc_tick && st_r.cnt == PWM_LAST)
		|=> st_r.duty == $past(st_r.duty))
		else $error("Duty changed away from a boundary");
	// A pending value is the one that lands at the boundary
	boundary_take_a: assert property (osc_tick && st_r.cnt == PWM_LAST && st_r.hold_valid
		|=> st_r.duty == $past(st_r.hold))
		else $error("Boundary did not load the held duty");
	// Without a fresh capture the boundary leaves nothing pending
	pending_clear_a: assert property (osc_tick && st_r.cnt == PWM_LAST && !(cs_rise && frame_ok)
		|=> !st_r.hold_valid)
		else $error("Held duty still pending after boundary");
	// A second write before the boundary replaces the first
	pending_overwrite_a: assert property (cs_rise && frame_ok && st_r.hold_valid
		|=> st_r.hold_valid && st_r.hold == $past(dec_duty))
		else $error("Pending duty not replaced");
	// New frames start with an empty bit count
	frame_start_a: assert property (!cs_f && st_r.cs_q |=> st_r.nbits == 5'h00)
		else $error("Bit count not cleared at frame start");
	// Reset is sampled in the antecedent so the release edge itself is skipped
	count_step_a: assert property (ARST_N && osc_tick |=> st_r.cnt == $past(st_r.cnt) + 9'h001)
		else $error("Period counter skipped a step");
endmodule

// ==== verification/sagp_host.sv ====
`timescale 1ns/1ps
// Host link master; link clock idles low between frames
module sagp_host (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic sdata
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
	end
	// D0 goes first; data moves with the fall, half a link period before each rise
	// Link period is ten core cycles; nclk other than 16 makes a frame to be refused
	task automatic send(input logic [15:0] frame, input int nclk = 16);
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nclk; i++)
		begin
			sdata <= frame[i[3:0]];
			repeat (5) @(posedge clk);
			sclk <= 1'b1;
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		// Released line shows the inverse, never a stale level
		sdata <= ~sdata;
		repeat (8) @(posedge clk);
	endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// Bench for the small-angle gauge channel, one-cycle oscillator
module tb;
	import sagp_pkg::*;
	logic clk; // Core clock
	logic arst_n; // Async reset
	logic cs_n; // Link select
	logic sclk; // Link clock
	logic sdata; // Link data
	logic pwm; // Inverted output
	int mismatches;
	int checks_done;
	sagp_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdata(sdata));
	sagp_channel #(.OSC_DIV(8'h01), .LAT_CYC(600)) dut_u (.CORE_CLK(clk), .ARST_N(arst_n),
		.CHIP_SELECT_N(cs_n), .SER_CLK(sclk), .SER_DATA(sdata), .PWM_OUT(pwm));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Low cycles across one 512-cycle period
	task automatic low_count(output logic [9:0] n);
		n = 10'h000;
		repeat (512) @(negedge clk) if (pwm === 1'b0) n = n + 10'h001;
	endtask
	// Only ignored bits of junk survive; duty MSB sits at D6
	function automatic logic [15:0] frame_of(input logic [8:0] duty, input logic [15:0] junk);
		logic [15:0] f;
		f = junk & 16'h8031;
		f[3:1] = 3'b100;
		for (int j = 0; j < 9; j++) f[6 + j] = duty[8 - j];
		return f;
	endfunction
	task automatic settle_and_check(input logic [8:0] duty);
		logic [9:0] n;
		repeat (1100) @(posedge clk);
		low_count(n);
		check(n, {1'b0, duty});
	endtask
	task automatic do_reset();
		@(posedge clk) arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
	endtask
	task automatic test_reset();
		logic [9:0] n;
		low_count(n);
		check(n, 10'h000);
		$display("test reset done");
	endtask
	// Duties 0x001, 0x0A5, 0x100 and 0x1FF, with ignored bits set and clear
	task automatic test_duties();
		logic [8:0] d[4] = '{9'h001, 9'h0A5, 9'h100, 9'h1FF};
		for (int i = 0; i < 4; i++)
		begin
			host_u.send(frame_of(d[i], i[0] ? 16'hFFFF : 16'h0000));
			settle_and_check(d[i]);
		end
		$display("test duties done");
	endtask
	// Two writes inside one period: only the second may ever reach the output
	task automatic test_overwrite();
		logic [9:0] n;
		// Duty 0x1FF is in use, so the lone high step marks a period's last count
		while (pwm !== 1'b1) @(negedge clk);
		host_u.send(frame_of(9'h0F0, 16'h0000));
		host_u.send(frame_of(9'h00F, 16'h0000));
		// The next fall is the first step of the period after the load
		while (pwm !== 1'b1) @(negedge clk);
		while (pwm !== 1'b0) @(negedge clk);
		low_count(n);
		check(n, 10'h00F);
		settle_and_check(9'h00F);
		$display("test overwrite done");
	endtask
	// Frames to another address or of the wrong length leave the duty alone
	task automatic test_foreign();
		logic [15:0] f;
		f = frame_of(9'h155, 16'h0000);
		f[3:1] = 3'h6;
		host_u.send(f);
		settle_and_check(9'h00F);
		host_u.send(frame_of(9'h155, 16'h0000), 17);
		settle_and_check(9'h00F);
		host_u.send(frame_of(9'h155, 16'h0000), 15);
		settle_and_check(9'h00F);
		$display("test foreign done");
	endtask
	// Reset in mid-run drops back to constant high
	task automatic test_rerun_reset();
		do_reset();
		test_reset();
		$display("test rerun reset done");
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		arst_n = 1'b0;
		mismatches = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		test_reset();
		test_duties();
		test_overwrite();
		test_foreign();
		test_rerun_reset();
		summarize();
	end
	// About 16000 cycles expected; cut off well beyond
	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
